// File: hdl/cng_map.vh
// Constants for the node guarding and emergency communication block
// Overview of operation
// - Identifier equals base plus node identifier
// - Each function range spans 127 identifiers
// - Identifiers 0, 128, 256 are broadcasts
// - PDO identifiers assigned automatically per function
// - SDO and guarding identifier ranges fixed
// - Guarding supervision disabled after reset
// - Guard time in milliseconds, resets zero
// - Life factor times guard time, resets zero
// - Guarding identifier fixed, not configurable
// - Supervision starts at first guard request
// - Operational reply toggles 5 and 133
// - Pre-operational reply toggles 127 and 255
// - Stopped reply toggles 4 and 132
// - Timeout enters guard fail, applies fault policy
// - Received PDOs still applied during guard fail
// - Resumed guarding leaves fail, stays pre-operational
// - Guard time zero answers without timer
// - Heartbeat supported as guarding alternative
// - Emergency identifier is 128 plus node
// - Node identifiers accepted only 1 to 127
// - Boot-up frame after reset, data zero
// - One emergency frame per pending error; events before its load merge, latest data kept; later ones before its accept cycle are dropped
`ifndef CNG_MAP_VH
`define CNG_MAP_VH
`define CNG_BASE_EMCY     11'h080
`define CNG_BASE_TPDO1    11'h180
`define CNG_BASE_RPDO1    11'h200
`define CNG_BASE_TPDO2    11'h280
`define CNG_BASE_RPDO2    11'h300
`define CNG_BASE_TPDO3    11'h380
`define CNG_BASE_RPDO3    11'h400
`define CNG_BASE_TPDO4    11'h480
`define CNG_BASE_RPDO4    11'h500
`define CNG_BASE_TSDO     11'h580
`define CNG_BASE_RSDO     11'h600
`define CNG_BASE_GUARD    11'h700
`define CNG_ID_NMT        11'h000
`define CNG_ID_SYNC       11'h080
`define CNG_ID_TIME       11'h100
`define CNG_RANGE_SPAN    7'h7F
`define CNG_NODE_MIN      7'h01
`define CNG_NODE_MAX      7'h7F
`define CNG_ST_STOPPED    8'h04
`define CNG_ST_OPER       8'h05
`define CNG_ST_PREOP      8'h7F
`define CNG_BOOTUP_DATA   8'h00
`define CNG_TOGGLE_BIT    7
`define CNG_GUARD_DLC     4'h1
`define CNG_EMCY_DLC      4'h8
`define CNG_CLK_MHZ       100
`define CNG_TICK_US       1000
`define CNG_TICK_CYCLES   (`CNG_CLK_MHZ * `CNG_TICK_US)
`define CNG_GUARD_RESET   16'h0000
`define CNG_LIFE_RESET    8'h00
`define CNG_NMT_START     8'h01
`define CNG_NMT_STOP      8'h02
`define CNG_NMT_PREOP     8'h80
`define CNG_NMT_RST_NODE  8'h81
`define CNG_NMT_RST_COMM  8'h82
`endif

// File: hdl/cng_id_calc.v
// Identifier arithmetic: one base plus node identifier
`timescale 1ns/1ns
module cng_id_calc
#(
	parameter [10:0] BASE = 11'h000
)
(
	input  wire [6:0]  node_id,
	output wire [10:0] cob_id
);
	assign cob_id = BASE + {4'h0, node_id};
endmodule

// File: hdl/cng_node_guard.v
// Node guarding responder, life supervision, boot-up and emergency framing
`timescale 1ns/1ns
`include "cng_map.vh"
module cng_node_guard
#(
	parameter TICK_CYCLES = `CNG_TICK_CYCLES
)
(
	input  wire        mclk,
	input  wire        rst,
	input  wire [6:0]  node_sw,
	input  wire [15:0] guard_time_ms,
	input  wire [7:0]  life_factor,
	input  wire        fault_hold_last,
	input  wire [7:0]  fault_out_value,
	input  wire        heartbeat_en,
	input  wire        rx_valid,
	input  wire [10:0] rx_id,
	input  wire        rx_rtr,
	input  wire [3:0]  rx_dlc,
	input  wire [7:0]  rx_byte0,
	input  wire [7:0]  rx_byte1,
	input  wire        tx_ready,
	input  wire        err_event,
	input  wire [15:0] err_code,
	input  wire [7:0]  err_reg,
	input  wire [39:0] err_info,
	input  wire [2:0]  err_info_len,
	output reg         tx_valid,
	output reg  [10:0] tx_id,
	output reg  [3:0]  tx_dlc,
	output reg  [63:0] tx_data,
	output reg  [7:0]  dout,
	output reg  [1:0]  nmt_state,
	output reg         guard_active,
	output reg         guard_fail,
	output reg         node_id_bad,
	output reg  [6:0]  node_id
);
	localparam [1:0] ST_PREOP = 2'h0;
	localparam [1:0] ST_OPER  = 2'h1;
	localparam [1:0] ST_STOP  = 2'h2;
	localparam [1:0] TX_IDLE  = 2'h0;
	localparam [1:0] TX_BOOT  = 2'h1;
	localparam [1:0] TX_GUARD = 2'h2;
	localparam [1:0] TX_EMCY  = 2'h3;
	localparam integer TICK_LAST_I = TICK_CYCLES - 1;
	localparam [16:0]  TICK_LAST   = TICK_LAST_I[16:0];
	reg  [6:0]  node_sync1_ff;
	reg  [6:0]  node_sync2_ff;
	reg  [6:0]  node_sync3_ff;
	reg  [6:0]  node_id_ff;
	reg         node_ok_ff;
	reg  [16:0] tick_cnt_ff;
	reg         tick_ff;
	reg         toggle_ff;
	reg         boot_pend_ff;
	reg         guard_pend_ff;
	reg         emcy_pend_ff;
	reg  [63:0] emcy_data_ff;
	reg  [23:0] life_cnt_ff;
	reg  [15:0] hb_cnt_ff;
	reg  [1:0]  tx_st_ff;
	reg  [7:0]  last_out_ff;
	reg         fail_pdo_ff;
	reg  [7:0]  guard_byte;
	reg  [39:0] info_masked;
	reg  [2:0]  i_len;
	integer     k;
	wire [10:0] guard_id;
	wire [10:0] emcy_id;
	wire [10:0] rpdo1_id;
	wire [23:0] life_limit;
	wire        is_nmt;
	wire        is_guard_rtr;
	wire        nmt_for_me;
	wire        rst_comm;
	wire        rst_any;
	// Only the fixed guarding base is used; no configurable identifier exists
	cng_id_calc #(.BASE(`CNG_BASE_GUARD)) u_guard_id
	(
		.node_id (node_id_ff),
		.cob_id  (guard_id)
	);
	cng_id_calc #(.BASE(`CNG_BASE_EMCY)) u_emcy_id
	(
		.node_id (node_id_ff),
		.cob_id  (emcy_id)
	);
	cng_id_calc #(.BASE(`CNG_BASE_RPDO1)) u_rpdo1_id
	(
		.node_id (node_id_ff),
		.cob_id  (rpdo1_id)
	);
	assign life_limit   = guard_time_ms * life_factor;
	assign is_nmt       = rx_valid && !rx_rtr && (rx_id == `CNG_ID_NMT);
	assign nmt_for_me   = is_nmt && ((rx_byte1 == 8'h00) || (rx_byte1 == {1'b0, node_id_ff}));
	assign is_guard_rtr = rx_valid && rx_rtr && node_ok_ff && (rx_id == guard_id)
	                      && (rx_dlc == `CNG_GUARD_DLC);
	assign rst_comm     = nmt_for_me && ((rx_byte0 == `CNG_NMT_RST_NODE) || (rx_byte0 == `CNG_NMT_RST_COMM));
	assign rst_any      = rst || rst_comm;
	// Switch input is asynchronous; accept only once two late stages agree
	always @(posedge mclk)
	begin
		if (rst)
		begin
			node_sync1_ff <= 7'h00;
			node_sync2_ff <= 7'h00;
			node_sync3_ff <= 7'h00;
			node_id_ff    <= 7'h00;
			node_ok_ff    <= 1'b0;
		end
		else
		begin
			node_sync1_ff <= node_sw;
			node_sync2_ff <= node_sync1_ff;
			node_sync3_ff <= node_sync2_ff;
			if (node_sync2_ff == node_sync3_ff)
			begin
				node_id_ff <= node_sync3_ff;
				node_ok_ff <= (node_sync3_ff >= `CNG_NODE_MIN) && (node_sync3_ff <= `CNG_NODE_MAX);
			end
		end
	end
	// Millisecond enable
	always @(posedge mclk)
	begin
		if (rst)
		begin
			tick_cnt_ff <= 17'h00000;
			tick_ff     <= 1'b0;
		end
		else if (tick_cnt_ff == TICK_LAST)
		begin
			tick_cnt_ff <= 17'h00000;
			tick_ff     <= 1'b1;
		end
		else
		begin
			tick_cnt_ff <= tick_cnt_ff + 17'h00001;
			tick_ff     <= 1'b0;
		end
	end
	// NMT state; a guard fail forces the node to pre-operational, from stopped as well
	always @(posedge mclk)
	begin
		if (rst_any)
			nmt_state <= ST_PREOP;
		else if (nmt_for_me)
		begin
			case (rx_byte0)
				`CNG_NMT_START: nmt_state <= ST_OPER;
				`CNG_NMT_STOP:  nmt_state <= ST_STOP;
				`CNG_NMT_PREOP: nmt_state <= ST_PREOP;
				default:        nmt_state <= nmt_state;
			endcase
		end
		else if (guard_active && (life_limit != 24'h000000) && tick_ff && (life_cnt_ff + 24'h000001 >= life_limit))
			nmt_state <= ST_PREOP;
	end
	// Guarding supervision
	always @(posedge mclk)
	begin
		if (rst_any)
		begin
			guard_active <= 1'b0;
			guard_fail   <= 1'b0;
			life_cnt_ff  <= 24'h000000;
			toggle_ff    <= 1'b0;
		end
		else if (is_guard_rtr)
		begin
			guard_active <= 1'b1;
			guard_fail   <= 1'b0;
			life_cnt_ff  <= 24'h000000;
			if (!guard_pend_ff)
				toggle_ff <= ~toggle_ff;
		end
		else if (guard_active && (life_limit != 24'h000000) && tick_ff && !guard_fail)
		begin
			if (life_cnt_ff + 24'h000001 >= life_limit)
				guard_fail <= 1'b1;
			else
				life_cnt_ff <= life_cnt_ff + 24'h000001;
		end
	end
	// Reply carries the toggle value taken before this request flipped it
	always @*
	begin
		case (nmt_state)
			ST_OPER: guard_byte = `CNG_ST_OPER;
			ST_STOP: guard_byte = `CNG_ST_STOPPED;
			default: guard_byte = `CNG_ST_PREOP;
		endcase
	end
	// Only the first err_info_len bytes survive; the rest read zero
	always @*
	begin
		i_len = (err_info_len > 3'h5) ? 3'h5 : err_info_len;
		for (k = 0; k < 5; k = k + 1)
			info_masked[k*8 +: 8] = (k < i_len) ? err_info[k*8 +: 8] : 8'h00;
	end
	// Heartbeat producer, reusing the guard time as period
	always @(posedge mclk)
	begin
		if (rst_any || !heartbeat_en || (guard_time_ms == 16'h0000))
			hb_cnt_ff <= 16'h0000;
		else if (tick_ff)
			hb_cnt_ff <= (hb_cnt_ff + 16'h0001 >= guard_time_ms) ? 16'h0000 : hb_cnt_ff + 16'h0001;
	end
	// Pending frames; a new request wins over the clear of a sent one
	always @(posedge mclk)
	begin
		if (rst)
		begin
			boot_pend_ff  <= 1'b1;
			guard_pend_ff <= 1'b0;
			emcy_pend_ff  <= 1'b0;
			emcy_data_ff  <= 64'h0000000000000000;
		end
		else
		begin
			if (rst_comm)
				boot_pend_ff <= 1'b1;
			else if (tx_st_ff == TX_BOOT && tx_valid && tx_ready)
				boot_pend_ff <= 1'b0;
			if (is_guard_rtr || (heartbeat_en && tick_ff && (guard_time_ms != 16'h0000)
			    && (hb_cnt_ff + 16'h0001 >= guard_time_ms)))
				guard_pend_ff <= 1'b1;
			else if (tx_st_ff == TX_GUARD && tx_valid && tx_ready)
				guard_pend_ff <= 1'b0;
			if (err_event && node_ok_ff)
			begin
				emcy_pend_ff <= 1'b1;
				emcy_data_ff <= {info_masked, err_reg, err_code[15:8], err_code[7:0]};
			end
			else if (tx_st_ff == TX_EMCY && tx_valid && tx_ready)
				emcy_pend_ff <= 1'b0;
		end
	end
	// Transmit arbiter: boot-up, then guarding, then emergency
	always @(posedge mclk)
	begin
		if (rst)
		begin
			tx_st_ff <= TX_IDLE;
			tx_valid <= 1'b0;
			tx_id    <= 11'h000;
			tx_dlc   <= 4'h0;
			tx_data  <= 64'h0000000000000000;
		end
		else
		begin
			case (tx_st_ff)
				TX_IDLE:
				begin
					if (node_ok_ff && boot_pend_ff)
					begin
						tx_st_ff <= TX_BOOT;
						tx_valid <= 1'b1;
						tx_id    <= guard_id;
						tx_dlc   <= `CNG_GUARD_DLC;
						tx_data  <= {56'h00000000000000, `CNG_BOOTUP_DATA};
					end
					else if (node_ok_ff && guard_pend_ff)
					begin
						tx_st_ff <= TX_GUARD;
						tx_valid <= 1'b1;
						tx_id    <= guard_id;
						tx_dlc   <= `CNG_GUARD_DLC;
						// Heartbeat frames carry no toggle
						tx_data  <= {56'h00000000000000, heartbeat_en ? 1'b0 : ~toggle_ff,
						             guard_byte[6:0]};
					end
					else if (node_ok_ff && emcy_pend_ff)
					begin
						tx_st_ff <= TX_EMCY;
						tx_valid <= 1'b1;
						tx_id    <= emcy_id;
						tx_dlc   <= `CNG_EMCY_DLC;
						tx_data  <= emcy_data_ff;
					end
				end
				TX_BOOT, TX_GUARD, TX_EMCY:
				begin
					if (tx_ready)
					begin
						tx_st_ff <= TX_IDLE;
						tx_valid <= 1'b0;
					end
				end
				default:
				begin
					tx_st_ff <= TX_IDLE;
					tx_valid <= 1'b0;
				end
			endcase
		end
	end
	// Output image: PDOs keep flowing in guard fail; policy applies until one lands
	always @(posedge mclk)
	begin
		if (rst)
		begin
			last_out_ff <= 8'h00;
			dout        <= 8'h00;
			fail_pdo_ff <= 1'b0;
		end
		else if (rx_valid && !rx_rtr && node_ok_ff && (rx_id == rpdo1_id) && (nmt_state == ST_OPER || guard_fail))
		begin
			last_out_ff <= rx_byte0;
			dout        <= rx_byte0;
			fail_pdo_ff <= guard_fail;
		end
		else if (guard_fail && !fault_hold_last && !fail_pdo_ff)
			dout <= fault_out_value;
		else
		begin
			dout        <= last_out_ff;
			fail_pdo_ff <= fail_pdo_ff && guard_fail;
		end
	end
	always @(posedge mclk)
	begin
		if (rst)
		begin
			node_id_bad <= 1'b0;
			node_id     <= 7'h00;
		end
		else
		begin
			node_id_bad <= ~node_ok_ff;
			node_id     <= node_id_ff;
		end
	end
endmodule

// File: tb/cng_props.sv
// Checker on the ports of the guarding and emergency block
`timescale 1ns/1ns
module cng_props
(
	input wire        mclk,
	input wire        rst,
	input wire [6:0]  node_id,
	input wire        node_id_bad,
	input wire        rx_valid,
	input wire [10:0] rx_id,
	input wire        rx_rtr,
	input wire [3:0]  rx_dlc,
	input wire        err_event,
	input wire        tx_ready,
	input wire        tx_valid,
	input wire [10:0] tx_id,
	input wire [3:0]  tx_dlc,
	input wire [63:0] tx_data,
	input wire        guard_fail,
	input wire [1:0]  nmt_state
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire rtr_ok = rx_valid && rx_rtr && rx_dlc == 4'h1 && rx_id == {4'hE, node_id} && !node_id_bad;
	chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) && $stable(tx_data))
		else $error("frame changed before accept");
	chk_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("no idle cycle after frame");
	chk_guard_id: assert property (tx_valid && tx_dlc == 4'h1 |-> tx_id == {4'hE, node_id})
		else $error("guard frame on wrong id");
	chk_emcy_id: assert property (tx_valid && tx_dlc == 4'h8 |-> tx_id == {4'h1, node_id})
		else $error("emergency on wrong id");
	chk_node_ok: assert property (tx_valid |-> !node_id_bad)
		else $error("frame sent with bad node id");
	chk_rtr_answer: assert property (rtr_ok |-> ##[2:40] tx_valid && tx_dlc == 4'h1)
		else $error("guard request not answered");
	chk_emcy_sent: assert property (err_event && !node_id_bad |-> ##[2:40] tx_valid && tx_dlc == 4'h8)
		else $error("error event without emergency");
	chk_fail_preop: assert property ($rose(guard_fail) |-> nmt_state == 2'd0)
		else $error("guard fail outside preop");
	chk_fail_clear: assert property (guard_fail && rtr_ok |-> ##[1:3] !guard_fail)
		else $error("guard fail kept after request");
	chk_stay_preop: assert property ($fell(guard_fail) |-> nmt_state == 2'd0)
		else $error("left preop on resume");
	cover property (rtr_ok ##[2:40] tx_valid);
	cover property ($rose(guard_fail));
	cover property (tx_valid && tx_ready && tx_dlc == 4'h8);
endmodule

// File: tb/cng_mgr.sv
// Manager model: sends frames, takes replies after a set stall
`timescale 1ns/1ns
module cng_mgr
(
	input  wire        mclk,
	input  wire [3:0]  lat,
	input  wire        tx_valid,
	input  wire [10:0] tx_id,
	input  wire [3:0]  tx_dlc,
	input  wire [63:0] tx_data,
	output reg         tx_ready,
	output reg         rx_valid,
	output reg  [10:0] rx_id,
	output reg         rx_rtr,
	output reg  [3:0]  rx_dlc,
	output reg  [7:0]  rx_byte0,
	output reg  [7:0]  rx_byte1
);
	integer    nfr = 0;
	reg [3:0]  wt_ff = 4'h0;
	reg [10:0] l_id;
	reg [3:0]  l_dlc;
	reg [63:0] l_dat;
	initial
	begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_id = 11'h7FF;
		rx_rtr = 1'b0;
		rx_dlc = 4'h0;
		rx_byte0 = 8'h00;
		rx_byte1 = 8'h00;
	end
	always @(posedge mclk)
	begin
		if (tx_valid && tx_ready)
		begin
			nfr <= nfr + 1;
			l_id <= tx_id;
			l_dlc <= tx_dlc;
			l_dat <= tx_data;
		end
		tx_ready <= tx_valid && !tx_ready && wt_ff >= lat;
		wt_ff <= (tx_valid && !tx_ready) ? wt_ff + 4'h1 : 4'h0;
	end
	task send(input [10:0] id, input r, input [3:0] d, input [7:0] b0, input [7:0] b1);
	begin
		@(posedge mclk);
		#1;
		rx_id = id;
		rx_rtr = r;
		rx_dlc = d;
		rx_byte0 = b0;
		rx_byte1 = b1;
		rx_valid = 1'b1;
		@(posedge mclk);
		#1;
		rx_valid = 1'b0;
		// Stale id and data bytes inverted so nothing can lean on old values
		rx_id = ~id;
		rx_byte0 = ~b0;
		rx_byte1 = ~b1;
	end
	endtask
endmodule

// File: tb/tb.sv
// Testbench for the guarding and emergency block
`timescale 1ns/1ns
module tb;
	localparam [6:0] NODE = 7'h05;
	reg         mclk = 1'b0;
	reg         rst = 1'b1;
	reg         fault_hold_last = 1'b0;
	reg         err_event = 1'b0;
	reg  [15:0] guard_time_ms = 16'h0000;
	reg  [15:0] err_code = 16'h2110;
	reg  [7:0]  life_factor = 8'h00;
	reg  [7:0]  err_reg = 8'h02;
	reg  [39:0] err_info = 40'hAABBCC0302;
	reg  [2:0]  err_info_len = 3'h2;
	reg  [3:0]  lat = 4'h0;
	reg         tg = 1'b0;
	reg  [6:0]  node_sw = NODE;
	reg         heartbeat_en = 1'b0;
	wire        rx_valid, rx_rtr, tx_ready, tx_valid, guard_active, guard_fail, node_id_bad;
	wire [10:0] rx_id, tx_id;
	wire [3:0]  rx_dlc, tx_dlc;
	wire [7:0]  rx_byte0, rx_byte1, dout;
	wire [63:0] tx_data;
	wire [1:0]  nmt_state;
	wire [6:0]  node_id;
	integer     miscompares = 0, compares = 0, cyc = 0, seen = 0;
	cng_node_guard #(.TICK_CYCLES(10)) i_cng_node_guard (.mclk(mclk), .rst(rst), .node_sw(node_sw),
		.guard_time_ms(guard_time_ms), .life_factor(life_factor), .fault_hold_last(fault_hold_last),
		.fault_out_value(8'h3C), .heartbeat_en(heartbeat_en), .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr),
		.rx_dlc(rx_dlc), .rx_byte0(rx_byte0), .rx_byte1(rx_byte1), .tx_ready(tx_ready), .err_event(err_event),
		.err_code(err_code), .err_reg(err_reg), .err_info(err_info), .err_info_len(err_info_len),
		.tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .dout(dout),
		.nmt_state(nmt_state), .guard_active(guard_active), .guard_fail(guard_fail),
		.node_id_bad(node_id_bad), .node_id(node_id));
	cng_mgr i_cng_mgr (.mclk(mclk), .lat(lat), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc),
		.tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr),
		.rx_dlc(rx_dlc), .rx_byte0(rx_byte0), .rx_byte1(rx_byte1));
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			miscompares = miscompares + 1;
			test_done;
		end
	end
	task chk(input [63:0] got, input [63:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task test_done;
	begin
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task wt(input integer n);
	begin
		repeat (n) @(posedge mclk);
		#1;
	end
	endtask
	// Waits for the next accepted frame, in order
	task wfr;
		integer k;
	begin
		k = 0;
		while (i_cng_mgr.nfr <= seen && k < 200)
		begin
			@(posedge mclk);
			k = k + 1;
		end
		#1;
		seen = seen + 1;
		chk(k < 200, 1);
	end
	endtask
	task rtr(input [7:0] base);
	begin
		i_cng_mgr.send(11'h700 + NODE, 1'b1, 4'h1, 8'h00, 8'h00);
		wfr;
		chk(i_cng_mgr.l_id, 11'h700 + NODE);
		chk(i_cng_mgr.l_dat[7:0], base | {tg, 7'h00});
		tg = ~tg;
	end
	endtask
	task nmt(input [7:0] cs);
	begin
		i_cng_mgr.send(11'h000, 1'b0, 4'h2, cs, {1'b0, NODE});
		wt(4);
	end
	endtask
	task t_boot;
	begin
		wfr;
		chk(i_cng_mgr.l_id, 11'h700 + NODE);
		chk(i_cng_mgr.l_dat[7:0], 8'h00);
		chk(guard_active, 1'b0);
		chk(node_id, NODE);
		chk(node_id_bad, 1'b0);
		$display("boot test done");
	end
	endtask
	task t_states;
		integer    i;
		reg [23:0] cs;
		reg [23:0] bs;
		reg [5:0]  st;
	begin
		cs = 24'h018002;
		bs = 24'h057F04;
		st = 6'b010010;
		lat = 4'h3;
		life_factor = 8'h02;
		for (i = 0; i < 3; i = i + 1)
		begin
			nmt(cs[23 - 8 * i -: 8]);
			chk(nmt_state, st[5 - 2 * i -: 2]);
			rtr(bs[23 - 8 * i -: 8]);
			rtr(bs[23 - 8 * i -: 8]);
		end
		chk(guard_active, 1'b1);
		i_cng_mgr.send(11'h700 + NODE, 1'b1, 4'h0, 8'h00, 8'h00);
		wt(100);
		chk(i_cng_mgr.nfr, seen);
		chk(guard_fail, 1'b0);
		$display("state test done");
	end
	endtask
	task t_fail;
	begin
		nmt(8'h01);
		rtr(8'h05);
		guard_time_ms = 16'h0002;
		life_factor = 8'h04;
		wt(40);
		chk(guard_fail, 1'b0);
		wt(50);
		chk(guard_fail, 1'b1);
		chk(nmt_state, 2'd0);
		chk(dout, 8'h3C);
		i_cng_mgr.send(11'h200 + NODE, 1'b0, 4'h1, 8'hA5, 8'h00);
		wt(4);
		chk(dout, 8'hA5);
		rtr(8'h7F);
		chk(guard_fail, 1'b0);
		chk(nmt_state, 2'd0);
		fault_hold_last = 1'b1;
		wt(90);
		chk(guard_fail, 1'b1);
		chk(dout, 8'hA5);
		rtr(8'h7F);
		guard_time_ms = 16'h0000;
		fault_hold_last = 1'b0;
		chk(guard_fail, 1'b0);
		$display("fail test done");
	end
	endtask
	task t_emcy;
	begin
		@(posedge mclk);
		#1;
		err_event = 1'b1;
		@(posedge mclk);
		#1;
		err_event = 1'b0;
		wfr;
		chk(i_cng_mgr.l_id, 11'h080 + NODE);
		chk(i_cng_mgr.l_dlc, 4'h8);
		chk(i_cng_mgr.l_dat, 64'h0000000302022110);
		wt(50);
		chk(i_cng_mgr.nfr, seen);
		$display("emergency test done");
	end
	endtask
	task t_rcomm;
	begin
		nmt(8'h82);
		wfr;
		chk(i_cng_mgr.l_dat[7:0], 8'h00);
		tg = 1'b0;
		rtr(8'h7F);
		$display("reset test done");
	end
	endtask
	task t_hbeat;
	begin
		life_factor = 8'h00;
		guard_time_ms = 16'h0002;
		heartbeat_en = 1'b1;
		wfr;
		chk(i_cng_mgr.l_id, 11'h700 + NODE);
		chk(i_cng_mgr.l_dat[7:0], 8'h7F);
		wfr;
		chk(i_cng_mgr.l_dat[7:0], 8'h7F);
		heartbeat_en = 1'b0;
		guard_time_ms = 16'h0000;
		wt(30);
		seen = i_cng_mgr.nfr;
		$display("heartbeat test done");
	end
	endtask
	task t_node;
	begin
		node_sw = 7'h00;
		wt(8);
		chk(node_id_bad, 1'b1);
		chk(node_id, 7'h00);
		i_cng_mgr.send(11'h700, 1'b1, 4'h1, 8'h00, 8'h00);
		wt(20);
		chk(i_cng_mgr.nfr, seen);
		node_sw = NODE;
		wt(8);
		chk(node_id_bad, 1'b0);
		chk(node_id, NODE);
		$display("node test done");
	end
	endtask
	initial
	begin
		wt(20);
		rst = 1'b0;
		t_boot;
		t_states;
		t_fail;
		t_emcy;
		t_rcomm;
		t_hbeat;
		t_node;
		test_done;
	end
endmodule
bind cng_node_guard cng_props i_cng_props (.mclk(mclk), .rst(rst), .node_id(node_id),
	.node_id_bad(node_id_bad), .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
	.err_event(err_event), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc),
	.tx_data(tx_data), .guard_fail(guard_fail), .nmt_state(nmt_state));
